// *** verilog/gpiop_defs.svh ***
// Purpose: Offsets, widths, masks and reset values of the port bank
// Assumes: Included by bare name; definitions only
// Notes: Slot order is port 0, 1, 2, 3, 7, 12
`ifndef GPIOP_DEFS_SVH
`define GPIOP_DEFS_SVH

// Register bus widths
`define GPIOP_AW 8
`define GPIOP_DW 8
`define GPIOP_NPORT 6

// Register groups: byte offset = group * 8 + port slot
`define GPIOP_OFS_DATA 8'h00
`define GPIOP_OFS_MODE 8'h08
`define GPIOP_OFS_PULL 8'h10
`define GPIOP_OFS_ASEL 8'h18
`define GPIOP_GRP_DATA 5'h00
`define GPIOP_GRP_MODE 5'h01
`define GPIOP_GRP_PULL 5'h02
`define GPIOP_GRP_ASEL 5'h03

// Slot of the analog-capable port
`define GPIOP_SLOT_ANA 3'h2
// Slot of the key-return port
`define GPIOP_SLOT_KEY 3'h4

// Implemented pins per slot (7, 8, 8, 4, 8, 5 bits)
`define GPIOP_WMASK0 8'h7F
`define GPIOP_WMASK1 8'hFF
`define GPIOP_WMASK2 8'hFF
`define GPIOP_WMASK3 8'h0F
`define GPIOP_WMASK4 8'hFF
`define GPIOP_WMASK5 8'h1F

// Pins that own a pull-up option
`define GPIOP_PUMASK0 8'h7F
`define GPIOP_PUMASK1 8'hFF
`define GPIOP_PUMASK2 8'h00
`define GPIOP_PUMASK3 8'h0F
`define GPIOP_PUMASK4 8'hFF
`define GPIOP_PUMASK5 8'h01

// Reset values
`define GPIOP_RST_DATA 8'h00
`define GPIOP_RST_PULL 8'h00
`define GPIOP_RST_ASEL 8'hFF

`endif

// *** verilog/gpiop_pkg.sv ***
// Purpose: Types shared by the port bank modules
// Assumes: Numbers live in gpiop_defs.svh
// Notes: Slot order is port 0, 1, 2, 3, 7, 12
`include "gpiop_defs.svh"
package gpiop_pkg;
    typedef logic [`GPIOP_DW-1:0] gpiop_byte_t;
    typedef logic [`GPIOP_NPORT-1:0][`GPIOP_DW-1:0] gpiop_bank_t;

    // Control state of the bank
    typedef struct packed {
        gpiop_bank_t latch;
        gpiop_bank_t mode;
        gpiop_bank_t pull;
        gpiop_byte_t asel;
        gpiop_byte_t rdata;
    } gpiop_ctrl_t;

    // State of one pad slice
    typedef struct packed {
        gpiop_byte_t sync1;
        gpiop_byte_t sync2;
        gpiop_byte_t pin;
        gpiop_byte_t oe;
        gpiop_byte_t pu;
    } gpiop_pad_t;
endpackage : gpiop_pkg

// *** verilog/gpiop_port_if.sv ***
// Purpose: Link between bank control and one pad slice
// Assumes: Single clock domain
// Notes: Drive fields are combinational, the slice registers them
interface gpiop_port_if;
    logic [7:0] drv_val;
    logic [7:0] drv_en;
    logic [7:0] pu_en;
    logic [7:0] pin_sync;
    modport ctrl (output drv_val, output drv_en, output pu_en, input pin_sync);
    modport pad (input drv_val, input drv_en, input pu_en, output pin_sync);
endinterface : gpiop_port_if

// *** verilog/gpiop_pad.sv ***
// Purpose: One port slice: input synchroniser and registered pad drive
// Assumes: Pin levels are asynchronous to clk_i
// Notes: Unimplemented bits are held at zero by the mask
module gpiop_pad #(
    parameter logic [7:0] WMASK = 8'hFF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Control side
    gpiop_port_if.pad pif,
    // Pin side
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    output logic [7:0] pull_up_o
);
    gpiop_pkg::gpiop_pad_t s_r;
    gpiop_pkg::gpiop_pad_t s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Next state: sync chain and masked drive
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = pin_i & WMASK;
        s_nxt.sync2 = s_r.sync1; // First stage feeds nothing else
        s_nxt.pin = pif.drv_val & WMASK;
        s_nxt.oe = pif.drv_en & WMASK;
        s_nxt.pu = pif.pu_en & WMASK;
    end

    // State register; reset leaves every driver off
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign pif.pin_sync = s_r.sync2;
    assign pin_o = s_r.pin;
    assign pin_oe_o = s_r.oe;
    assign pull_up_o = s_r.pu;
endmodule : gpiop_pad

// *** verilog/gpiop_bank.sv ***
// Purpose: Bank of six general-purpose ports with direction, pull-up and analog select
// Assumes: Register master on clk_i; pins asynchronous and synchronised here
// Notes: Slots 0..5 are ports 0, 1, 2, 3, 7 and 12; read data one cycle after strobe
//
// Design decisions made here: strobed register access and the register addresses.
`include "gpiop_defs.svh"

// Notes on behaviour
// - Each pin has its own direction bit, input or output independently.
// - Analog-capable port: eight pins, per-bit direction, no pull-up option.
// - Interrupt-capable port: four pins, per-bit direction, selectable pull-ups.
// - Key-return port: eight pins with pull-ups, also feeding key-return inputs.
// - Software enables or disables each available pull-up through a register.
// - Oscillator port: five pins, pull-up only on its lowest pin.
// - Every pin can be handed to a peripheral alternate function.
// - Reset puts every pin in input mode with drivers off.
// - Reset selects analog input on all eight analog-capable pins.
module gpiop_bank (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Register port
    input wire logic [`GPIOP_AW-1:0] addr_i,
    input wire logic [`GPIOP_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`GPIOP_DW-1:0] rdata_o,
    // Peripheral alternate functions
    input wire logic [5:0][7:0] alt_sel_i,
    input wire logic [5:0][7:0] alt_out_i,
    input wire logic [5:0][7:0] alt_oe_i,
    output logic [5:0][7:0] alt_in_o,
    output logic [7:0] key_return_inputs_o,
    output logic [7:0] analog_inputs_o,
    // Pins
    input wire logic [5:0][7:0] pin_i,
    output logic [5:0][7:0] pin_o,
    output logic [5:0][7:0] pin_oe_o,
    output logic [5:0][7:0] pull_up_o
);
    ////////////////////////////////////////////////////////////////////////
    // Per-slot constants
    localparam gpiop_pkg::gpiop_bank_t WMASK = {`GPIOP_WMASK5, `GPIOP_WMASK4,
        `GPIOP_WMASK3, `GPIOP_WMASK2, `GPIOP_WMASK1, `GPIOP_WMASK0};
    localparam gpiop_pkg::gpiop_bank_t PUMASK = {`GPIOP_PUMASK5, `GPIOP_PUMASK4,
        `GPIOP_PUMASK3, `GPIOP_PUMASK2, `GPIOP_PUMASK1, `GPIOP_PUMASK0};

    // Register map in short
    //   Group 0: output latch per slot, write always lands, read mixes pin and latch
    //   Group 1: direction per slot, one means input, reset value is the width mask
    //   Group 2: pull-up request per slot, bits without a resistor read zero
    //   Group 3: analog select, only at slot 0 of the group, one bit per analog pin
    //   Groups 4 and up, and slots 6 and 7 of any group, read zero and drop writes
    // Timing in short
    //   Write at edge n updates the register at edge n
    //   Pad drive, enable and pull-up follow at edge n plus one
    //   Read strobe at edge n gives data during the cycle after edge n only
    //   Pin changes reach the read mux after two synchroniser flops
    // Limitations
    //   Analog select wins over any driver, including a peripheral's
    //   Pull-up is dropped whenever the pin is driven, so a driven pin never fights it
    //   Unimplemented pins are masked in the pad, never driven and read as zero

    gpiop_pkg::gpiop_ctrl_t s_r;
    gpiop_pkg::gpiop_ctrl_t s_nxt;
    gpiop_pkg::gpiop_bank_t pin_sync;
    gpiop_pkg::gpiop_bank_t ana;
    gpiop_pkg::gpiop_bank_t rd_val;

    gpiop_port_if pif [`GPIOP_NPORT] ();

    // Address split: group of registers and port slot
    logic [4:0] grp;
    logic [2:0] slot;
    logic slot_ok;
    assign grp = addr_i[7:3];
    assign slot = addr_i[2:0];
    assign slot_ok = (slot < 3'(`GPIOP_NPORT));

    ////////////////////////////////////////////////////////////////////////
    // Per-slot drive, pull-up and read-back, one slice per port
    // Drive terms are combinational here and registered in the pad, so every
    // pin output leaves the bank straight from a flop. The read mux uses the
    // synchronised pin, never the raw pin, to keep metastability out of rdata.
    genvar g;
    generate
        for (g = 0; g < `GPIOP_NPORT; g++) begin : g_port
            // Analog select only exists on the analog-capable slot
            assign ana[g] = (3'(g) == `GPIOP_SLOT_ANA) ? s_r.asel : 8'h00;
            // Peripheral takes the pin when selected, else latch and mode bit
            assign pif[g].drv_val = (alt_sel_i[g] & alt_out_i[g]) |
                (~alt_sel_i[g] & s_r.latch[g]);
            // Analog selection masks any driver, so the prohibited mix stays safe
            assign pif[g].drv_en = ((alt_sel_i[g] & alt_oe_i[g]) |
                (~alt_sel_i[g] & ~s_r.mode[g])) & ~ana[g];
            // Pull-up only while the pin is not driven and the option exists
            assign pif[g].pu_en = s_r.pull[g] & PUMASK[g] & ~pif[g].drv_en;
            assign pin_sync[g] = pif[g].pin_sync;
            // Inputs read the pin, outputs read the latch; analog pins in input mode read zero
            assign rd_val[g] = ((s_r.mode[g] & pin_sync[g] & ~ana[g]) |
                (~s_r.mode[g] & s_r.latch[g])) & WMASK[g];
            gpiop_pad #(
                .WMASK(WMASK[g])
            ) u_pad (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .ce_i(ce_i),
                .pif(pif[g]),
                .pin_i(pin_i[g]),
                .pin_o(pin_o[g]),
                .pin_oe_o(pin_oe_o[g]),
                .pull_up_o(pull_up_o[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Register writes and read decode
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        if (wr_i) begin
            case (grp)
                `GPIOP_GRP_DATA: begin
                    if (slot_ok) begin
                        // Latch always updates, even in input mode
                        s_nxt.latch[slot] = wdata_i & WMASK[slot];
                    end
                end
                `GPIOP_GRP_MODE: begin
                    if (slot_ok) begin
                        s_nxt.mode[slot] = wdata_i & WMASK[slot];
                    end
                end
                `GPIOP_GRP_PULL: begin
                    if (slot_ok) begin
                        // Bits without a resistor stay zero
                        s_nxt.pull[slot] = wdata_i & PUMASK[slot];
                    end
                end
                `GPIOP_GRP_ASEL: begin
                    // One select register only; other slots of the group are holes
                    if (slot == 3'h0) begin
                        s_nxt.asel = wdata_i;
                    end
                end
                default: begin
                end
            endcase
        end
        if (rd_i) begin
            case (grp)
                `GPIOP_GRP_DATA: begin
                    // Mixed read-back: pin for inputs, latch for outputs
                    if (slot_ok) begin
                        s_nxt.rdata = rd_val[slot];
                    end
                end
                `GPIOP_GRP_MODE: begin
                    // Direction reads back as stored, already masked
                    if (slot_ok) begin
                        s_nxt.rdata = s_r.mode[slot];
                    end
                end
                `GPIOP_GRP_PULL: begin
                    // Pull request as stored, not the pad's effective pull-up
                    if (slot_ok) begin
                        s_nxt.rdata = s_r.pull[slot];
                    end
                end
                `GPIOP_GRP_ASEL: begin
                    // Analog select read-back
                    if (slot == 3'h0) begin
                        s_nxt.rdata = s_r.asel;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; all pins input, analog pins analog after reset
    // Reset values are constants only; the clock enable freezes every field,
    // read data included, so a read strobe under a low enable is simply lost.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r.latch <= {`GPIOP_NPORT{`GPIOP_RST_DATA}};
            s_r.mode <= WMASK;
            s_r.pull <= {`GPIOP_NPORT{`GPIOP_RST_PULL}};
            s_r.asel <= `GPIOP_RST_ASEL;
            s_r.rdata <= 8'h00;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    assign rdata_o = s_r.rdata;
    // Peripherals see the synchronised pins whatever the direction, so a
    // peripheral can watch its own output as driven back from the pad
    assign alt_in_o = pin_sync;
    // Key-return inputs see the synchronised port 7 pins
    assign key_return_inputs_o = pin_sync[`GPIOP_SLOT_KEY];
    assign analog_inputs_o = s_r.asel;
endmodule : gpiop_bank

// *** testbench/gpiop_bank_checker.sv ***
// Purpose: Port-level assertions on the port bank
// Assumes: One clock, ce_i held high by the bench
// Notes: Bound to gpiop_bank below
module gpiop_bank_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Alternate functions and pins
    input wire logic [5:0][7:0] alt_sel_i,
    input wire logic [5:0][7:0] alt_out_i,
    input wire logic [5:0][7:0] alt_in_o,
    input wire logic [7:0] key_return_inputs_o,
    input wire logic [7:0] analog_inputs_o,
    input wire logic [5:0][7:0] pin_o,
    input wire logic [5:0][7:0] pin_oe_o,
    input wire logic [5:0][7:0] pull_up_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////
    a_unimpl_pins: assert property (!pin_oe_o[0][7] && (pin_oe_o[3] & 8'hF0) == 8'h00
        && (pin_oe_o[5] & 8'hE0) == 8'h00) else $error("driver on missing pin");
    a_no_pull_p2: assert property (pull_up_o[2] == 8'h00)
        else $error("pull-up on analog port");
    a_one_pull_p12: assert property ((pull_up_o[5] & 8'hFE) == 8'h00)
        else $error("pull-up on upper oscillator pins");
    a_drive_no_pull: assert property ((pin_oe_o[1] & pull_up_o[1]) == 8'h00)
        else $error("pull-up while driving");
    a_rdata_once: assert property ((!$past(rd_i) || $past(addr_i) > 8'h1F) |->
        rdata_o == 8'h00) else $error("stray read data");
    a_analog_off: assert property ((analog_inputs_o & $past(analog_inputs_o)
        & pin_oe_o[2]) == 8'h00) else $error("analog pin driven");
    a_key_mirror: assert property (key_return_inputs_o == alt_in_o[4])
        else $error("key return differs from port");
    a_mode_drive: assert property (wr_i && addr_i == 8'h0B |->
        ##2 pin_oe_o[3] == (~$past(wdata_i, 2) & 8'h0F)) else $error("direction lost");
    a_alt_drive: assert property ($past(alt_sel_i[1]) == 8'hFF |->
        pin_o[1] == $past(alt_out_i[1])) else $error("alternate value not driven");
endmodule : gpiop_bank_checker

bind gpiop_bank gpiop_bank_checker i_gpiop_bank_checker (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .alt_sel_i(alt_sel_i), .alt_out_i(alt_out_i), .alt_in_o(alt_in_o),
    .key_return_inputs_o(key_return_inputs_o), .analog_inputs_o(analog_inputs_o),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o));

// *** testbench/gpiop_board.sv ***
// Purpose: Board wiring seen by the port pins
// Assumes: Bench never drives a pin the device drives
// Notes: Undriven pins without pull-up toggle each cycle
module gpiop_board (
    // Clock
    input wire logic clk_i,
    // Device side
    input wire logic [5:0][7:0] pin_o,
    input wire logic [5:0][7:0] pin_oe_o,
    input wire logic [5:0][7:0] pull_up_o,
    // Bench side
    input wire logic [5:0][7:0] ext_val_i,
    input wire logic [5:0][7:0] ext_en_i,
    output logic [5:0][7:0] pin_lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flt_r = 1'b0;
    // Floating level keeps moving so an open pin never reads stable
    always_ff @(posedge clk_i) begin
        flt_r <= ~flt_r;
    end
    // Device drive, else board drive, else pull-up, else float
    assign pin_lvl_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i)
        | (~pin_oe_o & ~ext_en_i & (pull_up_o | {48{flt_r}}));
endmodule : gpiop_board

// *** testbench/tb_top.sv ***
// Purpose: Register-driven test of the port bank
// Assumes: ce_i held high throughout
// Notes: Slots 0..5 are ports 0, 1, 2, 3, 7, 12
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, key_o, ana_o;
    logic [5:0][7:0] sel = '0, aout = '0, aoe = '0, ain, pin_i, pin_o, oe, pu;
    logic [5:0][7:0] ext_val = '0, ext_en = '0;
    logic [7:0] wm [6] = '{8'h7F, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h1F};
    logic [7:0] pm [6] = '{8'h7F, 8'hFF, 8'h00, 8'h0F, 8'hFF, 8'h01};
    int err_count = 0, n_tests = 0;
    gpiop_bank i_gpiop_bank (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .alt_sel_i(sel), .alt_out_i(aout), .alt_oe_i(aoe), .alt_in_o(ain),
        .key_return_inputs_o(key_o), .analog_inputs_o(ana_o), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(oe), .pull_up_o(pu));
    gpiop_board i_gpiop_board (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(oe), .pull_up_o(pu),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_lvl_o(pin_i));
    ////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd
    task automatic tally_and_finish;
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////
    // Watchdog sized well above the sequence length
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        tick(1);
        chk(ana_o, 8'hFF);
        for (int s = 0; s < 6; s++) begin
            chk(oe[s], 8'h00);
            rd(8'h08 + 8'(s), wm[s]);
            rd(8'h10 + 8'(s), 8'h00);
            wr(8'h10 + 8'(s), 8'hFF);
            rd(8'h10 + 8'(s), pm[s]);
            tick(1);
            chk(pu[s], pm[s]);
        end
        rd(8'h18, 8'hFF);
        wr(8'h20, 8'h55);
        rd(8'h20, 8'h00);
        // Mixed direction on port 1, board drives the input half
        ext_val[1] <= 8'h3C;
        ext_en[1] <= 8'hF0;
        wr(8'h01, 8'hA5);
        wr(8'h09, 8'hF0);
        tick(4);
        chk(oe[1], 8'h0F);
        chk(pin_o[1], 8'hA5);
        chk(pu[1], 8'hF0);
        rd(8'h01, 8'h35);
        // Analog port blocks output until digital is selected
        wr(8'h02, 8'hFF);
        wr(8'h0A, 8'h00);
        tick(2);
        chk(oe[2], 8'h00);
        rd(8'h02, 8'hFF);
        wr(8'h18, 8'h00);
        tick(2);
        chk(ana_o, 8'h00);
        chk(oe[2], 8'hFF);
        // Key-return port follows the board
        ext_val[4] <= 8'h5A;
        ext_en[4] <= 8'hFF;
        tick(5);
        chk(key_o, 8'h5A);
        chk(ain[4], 8'h5A);
        rd(8'h04, 8'h5A);
        // Direction on ports 3 and 12
        wr(8'h0B, 8'h0A);
        wr(8'h0D, 8'h00);
        tick(2);
        chk(oe[3], 8'h05);
        chk(oe[5], 8'h1F);
        // Peripheral takes pin 0 of port 0 and all of port 1
        @(posedge clk_i);
        sel[0] <= 8'h01;
        aoe[0] <= 8'h01;
        aout[0] <= 8'h01;
        sel[1] <= 8'hFF;
        aoe[1] <= 8'h00;
        aout[1] <= 8'h96;
        tick(3);
        chk(oe[0], 8'h01);
        chk(pin_o[0], 8'h01);
        chk(pu[0], 8'h7E);
        chk(oe[1], 8'h00);
        tally_and_finish();
    end
endmodule : tb_top
